// [hdl/ewp_ctrl.sv]
// write-protect control of a two-wire serial eeprom: bus front end on the
// link clock, unlock latches, protection bits and write-cycle timer on the
// system clock.
// assumes open-drain sda resolved outside; the array itself lives outside.
//
// Operation
// - reset clears both unlock latches
// - array latch low: nack array data, ignore
// - 02h to register sets array latch
// - array latch holds until 00h written
// - latch-only writes start no timed cycle
// - config latch low: protection bits frozen
// - config latch clears after any timed write
// - config latch set: array latch cannot clear
// - 02h with config latch programs bits
// - 06h after array latch sets config latch
// - final byte carries arm and lock bits
// - steps two and three repeat per change
// - config bit set in final byte: ignored
// - pin and arm high abort final-step write
// - final step runs timed busy cycle
// - start instead of stop drops the write
// - lock code selects protected array range
// - protection bits locked by pin and arm
// - locked array write acked, then discarded
// - register write takes one clean byte
// - unused register bits zero both ways
// - busy device ignores its slave address
`timescale 1ns/1ps
`default_nettype none
`include "ewp_consts.svh"
module ewp_ctrl #(
  parameter int unsigned P_NV_CYCLES = `EWP_NV_CYCLES
) (
  // system clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_arst_n,
  // two-wire link
  input  wire logic        i_clk_link,
  input  wire logic        i_scl,
  input  wire logic        i_sda_i,
  output logic             o_sda_o,
  output logic             o_sda_oe,
  // pins
  input  wire logic        i_wp,
  input  wire logic [2:0]  i_dev_sel,
  // array side
  output logic             o_arr_commit,
  output logic      [15:0] o_arr_addr,
  // status
  output logic             o_busy,
  output logic      [7:0]  o_wpr
);
  localparam int unsigned CW = $clog2(P_NV_CYCLES + 1);

  typedef struct packed {
    logic                   array_write_unlock;
    logic                   config_write_unlock;
    logic [1:0]             bl;
    logic                   arm;
    logic                   busy;
    logic [CW-1:0]          cnt;
    logic [`EWP_STAT_W-1:0] sent;
    logic                   commit;
    logic [15:0]            caddr;
  } ewp_sys_t;

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic ewp_is_reg(input logic [15:0] a);
    return a == `EWP_REG_ADDR;
  endfunction

  function automatic logic ewp_locked(input logic [1:0] bl, input logic [15:0] a);
    logic hit;
    hit = 1'b0;
    case (bl)
      2'b00: hit = 1'b0;
      2'b01: hit = (a[13:0] >= `EWP_QTR_BASE);
      2'b10: hit = (a[13:0] >= `EWP_HALF_BASE);
      default: hit = 1'b1;
    endcase
    return hit;
  endfunction

  ewp_sys_t                r;
  ewp_sys_t                next_r;
  ewp_pkg::ewp_link_t      l;
  ewp_pkg::ewp_link_t      next_l;
  logic                    wp_s;
  logic                    scl_s;
  logic                    sda_s;
  logic [2:0]              sel_s;
  logic                    m_valid;
  logic [`EWP_MSG_W-1:0]   m_word;
  logic [15:0]             m_addr;
  logic [7:0]              m_data;
  logic                    msg_ready;
  logic                    st_valid;
  logic [`EWP_STAT_W-1:0]  st_word;
  logic                    st_ready;
  logic [`EWP_STAT_W-1:0]  stat_now;
  logic [7:0]              write_protect_control;
  logic                    hw_lock;
  logic                    m_clean;
  logic                    s3_hit;
  logic                    scl_rise;
  logic                    scl_fall;
  logic                    start_c;
  logic                    stop_c;
  logic                    ack_c;
  logic [7:0]              tx_byte;

  // ----------------------------------------
  // pin synchronisers and domain crossings
  // ----------------------------------------
  ewp_sync #(.W(1), .INIT(1'b0)) u_wp_sync (
    .i_clk(i_clk_sys), .i_arst_n(i_arst_n), .i_d(i_wp), .o_q(wp_s));
  ewp_sync #(.W(2), .INIT(2'h3)) u_bus_sync (
    .i_clk(i_clk_link), .i_arst_n(i_arst_n), .i_d({i_scl, i_sda_i}),
    .o_q({scl_s, sda_s}));
  ewp_sync #(.W(3), .INIT(3'h0)) u_sel_sync (
    .i_clk(i_clk_link), .i_arst_n(i_arst_n), .i_d(i_dev_sel), .o_q(sel_s));

  // finished writes travel link to system as {word address, first data}
  ewp_xfer #(.W(`EWP_MSG_W)) u_msg_xfer (
    .i_arst_n(i_arst_n), .i_src_clk(i_clk_link),
    .i_valid(l.send), .i_data({l.addr, l.data}), .o_ready(msg_ready),
    .i_dst_clk(i_clk_sys), .o_valid(m_valid), .o_data(m_word));

  // register image and busy flag travel back whenever they change
  ewp_xfer #(.W(`EWP_STAT_W)) u_stat_xfer (
    .i_arst_n(i_arst_n), .i_src_clk(i_clk_sys),
    .i_valid(stat_now != r.sent), .i_data(stat_now), .o_ready(st_ready),
    .i_dst_clk(i_clk_link), .o_valid(st_valid), .o_data(st_word));

  assign m_addr   = m_word[23:8];
  assign m_data   = m_word[7:0];
  assign write_protect_control      = {r.arm, 2'b00, r.bl, r.config_write_unlock, r.array_write_unlock, 1'b0};
  assign stat_now = {r.busy, write_protect_control};
  assign hw_lock  = wp_s && r.arm;
  assign m_clean  = ((m_data & `EWP_UNUSED_MASK) == 8'h00);
  assign s3_hit   = m_valid && !r.busy && r.config_write_unlock && ewp_is_reg(m_addr) && m_clean
                    && ((m_data & `EWP_STEP3_MASK) == `EWP_STEP3_VAL);

  // ----------------------------------------
  // system domain: latches, protection bits, write-cycle timer
  // ----------------------------------------
  always_comb begin
    next_r        = r;
    next_r.commit = 1'b0;
    if (stat_now != r.sent && st_ready) begin
      next_r.sent = stat_now;
    end
    if (r.busy) begin
      // writes that land while busy are dropped; the link nacks them anyway
      if (r.cnt == CW'(1)) begin
        next_r.busy = 1'b0;
        next_r.cnt  = '0;
        next_r.config_write_unlock = 1'b0;
      end else begin
        next_r.cnt = r.cnt - CW'(1);
      end
    end else if (m_valid && ewp_is_reg(m_addr)) begin
      if (!m_clean) begin
        next_r.array_write_unlock = r.array_write_unlock;
      end else if (!r.config_write_unlock) begin
        if (m_data == `EWP_CMD_ARR_SET) begin
          next_r.array_write_unlock = 1'b1;
        end else if (m_data == `EWP_CMD_ARR_CLR) begin
          next_r.array_write_unlock = 1'b0;
        end else if (m_data == `EWP_CMD_CFG_SET && r.array_write_unlock) begin
          next_r.config_write_unlock = 1'b1;
        end
      end else if (s3_hit && !hw_lock) begin
        // only the final pattern passes; 00h and 06h fall through untouched
        next_r.arm  = m_data[`EWP_BIT_ARM];
        next_r.bl   = {m_data[`EWP_BIT_BLHI], m_data[`EWP_BIT_BLLO]};
        next_r.busy = 1'b1;
        next_r.cnt  = CW'(P_NV_CYCLES);
      end
    end else if (m_valid && r.array_write_unlock && !ewp_locked(r.bl, m_addr)) begin
      next_r.commit = 1'b1;
      next_r.caddr  = m_addr;
      next_r.busy   = 1'b1;
      next_r.cnt    = CW'(P_NV_CYCLES);
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      r <= '{arm: `EWP_ARM_RESET, bl: `EWP_BL_RESET, default: '0};
    end else begin
      r <= next_r;
    end
  end

  assign o_busy       = r.busy;
  assign o_wpr        = write_protect_control;
  assign o_arr_commit = r.commit;
  assign o_arr_addr   = r.caddr;

  // ----------------------------------------
  // link domain: two-wire slave front end
  // ----------------------------------------
  assign scl_rise = scl_s && !l.scl_q;
  assign scl_fall = !scl_s && l.scl_q;
  assign start_c  = scl_s && l.scl_q && l.sda_q && !sda_s;
  assign stop_c   = scl_s && l.scl_q && !l.sda_q && sda_s;
  assign tx_byte  = ewp_is_reg(l.addr) ? l.stat[7:0] : `EWP_IDLE_BYTE;

  always_comb begin
    next_l       = l;
    next_l.scl_q = scl_s;
    next_l.sda_q = sda_s;
    next_l.send  = 1'b0;
    ack_c        = 1'b1;
    if (st_valid) begin
      next_l.stat = st_word;
    end
    if (start_c) begin
      next_l.st      = ewp_pkg::ewp_l_rx;
      next_l.cnt     = 4'h0;
      next_l.bidx    = 3'h0;
      next_l.wr_pend = 1'b0;
      next_l.oe      = 1'b0;
    end else if (stop_c) begin
      // a message is dropped if the previous one is still crossing
      next_l.send    = l.wr_pend && !l.rw && msg_ready;
      next_l.wr_pend = 1'b0;
      next_l.st      = ewp_pkg::ewp_l_idle;
      next_l.oe      = 1'b0;
    end else begin
      case (l.st)
        ewp_pkg::ewp_l_rx: begin
          if (scl_rise) begin
            next_l.sh  = {l.sh[6:0], sda_s};
            next_l.cnt = 4'(l.cnt + 4'h1);
          end else if (scl_fall && l.cnt == 4'h8) begin
            if (l.bidx == 3'h0) begin
              ack_c     = (l.sh[7:1] == {`EWP_DEV_TYPE, sel_s}) && !l.stat[8];
              next_l.rw = l.sh[0];
            end else if (l.bidx == 3'h1) begin
              next_l.addr[15:8] = l.sh;
            end else if (l.bidx == 3'h2) begin
              next_l.addr[7:0] = l.sh;
            end else begin
              if (ewp_is_reg(l.addr)) begin
                ack_c = (l.bidx == 3'h3);
              end else begin
                ack_c = l.stat[`EWP_BIT_ARR];
              end
              if (l.bidx == 3'h3) begin
                next_l.data = l.sh;
              end
              next_l.wr_pend = l.wr_pend || ack_c;
            end
            next_l.oe   = ack_c;
            next_l.bidx = (l.bidx == 3'h4) ? 3'h4 : 3'(l.bidx + 3'h1);
            next_l.st   = ewp_pkg::ewp_l_ack;
          end
        end
        ewp_pkg::ewp_l_ack: begin
          if (scl_fall) begin
            next_l.cnt = 4'h0;
            if (!l.oe) begin
              next_l.st = ewp_pkg::ewp_l_skip;
            end else if (l.rw) begin
              next_l.oe     = ~tx_byte[7];
              next_l.sh     = {tx_byte[6:0], 1'b0};
              next_l.rd_reg = ewp_is_reg(l.addr);
              next_l.st     = ewp_pkg::ewp_l_tx;
              if (ewp_is_reg(l.addr)) begin
                next_l.addr = `EWP_ADDR_ROLL;
              end
            end else begin
              next_l.oe = 1'b0;
              next_l.st = ewp_pkg::ewp_l_rx;
            end
          end
        end
        ewp_pkg::ewp_l_tx: begin
          if (scl_rise) begin
            next_l.cnt = 4'(l.cnt + 4'h1);
          end else if (scl_fall && l.cnt == 4'h8) begin
            next_l.oe = 1'b0;
            next_l.st = ewp_pkg::ewp_l_mack;
          end else if (scl_fall) begin
            next_l.oe = ~l.sh[7];
            next_l.sh = {l.sh[6:0], 1'b0};
          end
        end
        ewp_pkg::ewp_l_mack: begin
          // register reads end after one byte; array bytes are not sourced here
          if (scl_rise && !sda_s && !l.rd_reg) begin
            next_l.sh  = `EWP_IDLE_BYTE;
            next_l.cnt = 4'h0;
            next_l.st  = ewp_pkg::ewp_l_tx;
          end else if (scl_rise) begin
            next_l.st = ewp_pkg::ewp_l_skip;
          end
        end
        default: begin
          next_l.oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_link or negedge i_arst_n) begin
    if (!i_arst_n) begin
      l <= '{st: ewp_pkg::ewp_l_idle, scl_q: 1'b1, sda_q: 1'b1, default: '0};
    end else begin
      l <= next_l;
    end
  end

  assign o_sda_o  = 1'b0;
  assign o_sda_oe = l.oe;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [CW-1:0] busy_age;

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      busy_age <= '0;
    end else if (!r.busy) begin
      busy_age <= '0;
    end else begin
      busy_age <= CW'(busy_age + CW'(1));
    end
  end

  default clocking ewp_cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_arst_n);

  a_arr_set: assert property (
    m_valid && !r.busy && !r.config_write_unlock && ewp_is_reg(m_addr) && m_data == `EWP_CMD_ARR_SET
    |=> r.array_write_unlock) else $error("array latch not set by 02h");
  a_arr_clear: assert property (
    m_valid && !r.busy && !r.config_write_unlock && ewp_is_reg(m_addr) && m_data == `EWP_CMD_ARR_CLR
    |=> !r.array_write_unlock) else $error("array latch not cleared by 00h");
  a_latch_volatile: assert property (
    m_valid && !r.busy && !r.config_write_unlock && ewp_is_reg(m_addr)
    |=> !r.busy ##1 !r.busy) else $error("latch write started a timed cycle");
  a_cfg_set: assert property (
    m_valid && !r.busy && !r.config_write_unlock && r.array_write_unlock && ewp_is_reg(m_addr)
    && m_data == `EWP_CMD_CFG_SET |=> r.config_write_unlock) else $error("config latch not set");
  a_bits_frozen: assert property (
    !r.config_write_unlock |=> $stable({r.arm, r.bl})) else $error("protection bits moved while locked");
  a_no_dual_clear: assert property (
    r.config_write_unlock |=> r.array_write_unlock) else $error("array latch cleared under config latch");
  a_step3_prog: assert property (
    s3_hit && !hw_lock |=> r.busy && r.config_write_unlock
    && {r.arm, r.bl} == $past({m_data[7], m_data[4:3]})) else $error("final step lost");
  a_cfg_end: assert property (
    $fell(r.busy) |-> !r.config_write_unlock) else $error("config latch survived a timed write");
  a_hw_abort: assert property (
    s3_hit && hw_lock |=> !r.busy && r.config_write_unlock && $stable({r.arm, r.bl}))
    else $error("armed register write not aborted");
  a_bad_step3: assert property (
    m_valid && !r.busy && r.config_write_unlock && ewp_is_reg(m_addr) && m_data[`EWP_BIT_CFG]
    |=> r.config_write_unlock && !r.busy && $stable({r.arm, r.bl})) else $error("config bit byte acted");
  a_lock_skip: assert property (
    m_valid && !r.busy && !ewp_is_reg(m_addr) && ewp_locked(r.bl, m_addr)
    |=> !r.commit && !r.busy) else $error("locked array write went through");
  a_busy_len: assert property (
    $fell(r.busy) |-> busy_age == CW'(P_NV_CYCLES)) else $error("write cycle length wrong");
  a_nack_locked: assert property (
    @(posedge i_clk_link) disable iff (!i_arst_n)
    l.st == ewp_pkg::ewp_l_rx && scl_fall && l.cnt == 4'h8 && l.bidx >= 3'h3
    && !ewp_is_reg(l.addr) && !l.stat[`EWP_BIT_ARR] |=> !l.oe && !l.wr_pend)
    else $error("data acked with array latch low");
  a_busy_nack: assert property (
    @(posedge i_clk_link) disable iff (!i_arst_n)
    l.st == ewp_pkg::ewp_l_rx && scl_fall && l.cnt == 4'h8 && l.bidx == 3'h0
    && l.stat[8] |=> !l.oe) else $error("busy device acked its address");
endmodule
`default_nettype wire

// [common/ewp_consts.svh]
// constants of the eeprom write-protect control block
// assumes inclusion by bare name from the package and the design files
`ifndef EWP_CONSTS_SVH
`define EWP_CONSTS_SVH
// ----------------------------------------
// register address and field layout
// ----------------------------------------
`define EWP_REG_ADDR    16'hffff
`define EWP_BIT_ARM     7
`define EWP_BIT_BLHI    4
`define EWP_BIT_BLLO    3
`define EWP_BIT_CFG     2
`define EWP_BIT_ARR     1
`define EWP_UNUSED_MASK 8'h61
`define EWP_ARM_RESET   1'h0
`define EWP_BL_RESET    2'h0
// ----------------------------------------
// data byte commands
// ----------------------------------------
`define EWP_CMD_ARR_SET 8'h02
`define EWP_CMD_ARR_CLR 8'h00
`define EWP_CMD_CFG_SET 8'h06
`define EWP_STEP3_MASK  8'h07
`define EWP_STEP3_VAL   8'h02
// ----------------------------------------
// lock ranges and bus constants
// ----------------------------------------
`define EWP_QTR_BASE    14'h3000
`define EWP_HALF_BASE   14'h2000
`define EWP_DEV_TYPE    4'ha
`define EWP_IDLE_BYTE   8'hff
`define EWP_ADDR_ROLL   16'h0000
`define EWP_STAT_W      9
`define EWP_MSG_W       24
// ----------------------------------------
// timing
// ----------------------------------------
`define EWP_CLK_MHZ     50
`define EWP_NV_CYCLE_US 10000
`define EWP_NV_CYCLES   (`EWP_NV_CYCLE_US * `EWP_CLK_MHZ)
`endif

// [common/ewp_pkg.sv]
// types of the eeprom write-protect control block
// assumes ewp_consts.svh on the include path
`include "ewp_consts.svh"
package ewp_pkg;
  typedef enum logic [5:0] {
    ewp_l_idle = 6'h01,
    ewp_l_rx   = 6'h02,
    ewp_l_ack  = 6'h04,
    ewp_l_tx   = 6'h08,
    ewp_l_mack = 6'h10,
    ewp_l_skip = 6'h20
  } ewp_lstate_t;

  typedef struct packed {
    ewp_lstate_t             st;
    logic [3:0]              cnt;
    logic [7:0]              sh;
    logic [2:0]              bidx;
    logic                    rw;
    logic                    rd_reg;
    logic                    wr_pend;
    logic                    oe;
    logic                    scl_q;
    logic                    sda_q;
    logic                    send;
    logic [15:0]             addr;
    logic [7:0]              data;
    logic [`EWP_STAT_W-1:0]  stat;
  } ewp_link_t;
endpackage

// [hdl/ewp_sync.sv]
// three-stage input synchroniser with agreement filter
// assumes an asynchronous input and one destination clock
`timescale 1ns/1ps
`default_nettype none
module ewp_sync #(
  parameter int unsigned    W    = 1,
  parameter logic [W-1:0]   INIT = '0
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_arst_n,
  // data
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } ewp_sync_t;

  ewp_sync_t r;
  ewp_sync_t next_r;

  // a bit moves only once stages two and three agree on it
  always_comb begin
    next_r    = r;
    next_r.s1 = i_d;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    next_r.q  = (r.s2 & ~(r.s2 ^ r.s3)) | (r.q & (r.s2 ^ r.s3));
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      r <= {4{INIT}};
    end else begin
      r <= next_r;
    end
  end

  assign o_q = r.q;
endmodule
`default_nettype wire

// [hdl/ewp_xfer.sv]
// toggle handshake carrying one word between two clock domains
// assumes the source holds off while o_ready is low
`timescale 1ns/1ps
`default_nettype none
module ewp_xfer #(
  parameter int unsigned W = 8
) (
  // reset
  input  wire logic         i_arst_n,
  // source side
  input  wire logic         i_src_clk,
  input  wire logic         i_valid,
  input  wire logic [W-1:0] i_data,
  output logic              o_ready,
  // destination side
  input  wire logic         i_dst_clk,
  output logic              o_valid,
  output logic      [W-1:0] o_data
);
  typedef struct packed {
    logic         req;
    logic [W-1:0] hold;
  } ewp_xsrc_t;
  typedef struct packed {
    logic         ack;
    logic         valid;
    logic [W-1:0] data;
  } ewp_xdst_t;

  ewp_xsrc_t s;
  ewp_xsrc_t next_s;
  ewp_xdst_t d;
  ewp_xdst_t next_d;
  logic      req_s;
  logic      ack_s;

  ewp_sync #(.W(1), .INIT(1'b0)) u_req (
    .i_clk(i_dst_clk), .i_arst_n(i_arst_n), .i_d(s.req), .o_q(req_s));
  ewp_sync #(.W(1), .INIT(1'b0)) u_ack (
    .i_clk(i_src_clk), .i_arst_n(i_arst_n), .i_d(d.ack), .o_q(ack_s));

  assign o_ready = (ack_s == s.req);

  // hold stays put until the ack returns, so the far side samples a still word
  always_comb begin
    next_s = s;
    if (i_valid && o_ready) begin
      next_s.req  = ~s.req;
      next_s.hold = i_data;
    end
  end

  always_comb begin
    next_d       = d;
    next_d.valid = 1'b0;
    if (req_s != d.ack) begin
      next_d.ack   = req_s;
      next_d.valid = 1'b1;
      next_d.data  = s.hold;
    end
  end

  always_ff @(posedge i_src_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  always_ff @(posedge i_dst_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      d <= '0;
    end else begin
      d <= next_d;
    end
  end

  assign o_valid = d.valid;
  assign o_data  = d.data;
endmodule
`default_nettype wire

// [testbench/ewp_bus_master.sv]
// two-wire bus master model, behavioural, about 500 kHz bit rate
// assumes the wire is resolved outside with a pull-up
`timescale 1ns/1ps
`default_nettype none
module ewp_bus_master (
  // bus
  output logic        o_scl,
  output logic        o_sda,
  input  wire logic   i_sda
);
  localparam int Q = 500;
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // ----------------------------------------
  // conditions
  // ----------------------------------------
  task automatic start();
    o_sda = 1'b1;
    #Q o_scl = 1'b1;
    #Q o_sda = 1'b0;
    #Q o_scl = 1'b0;
    #Q;
  endtask
  // final step closes with stop so the timed write launches
  task automatic stop();
    o_sda = 1'b0;
    #Q o_scl = 1'b1;
    #Q o_sda = 1'b1;
    #Q;
  endtask
  // sda only changes while scl is low; released for the ack bit
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      o_sda = b[i];
      #Q o_scl = 1'b1;
      #(2*Q) o_scl = 1'b0;
      #Q;
    end
    o_sda = 1'b1;
    #Q o_scl = 1'b1;
    #Q ack = ~i_sda;
    #Q o_scl = 1'b0;
    #Q;
  endtask
  // read one byte from the slave, then answer with ack (0) or nack (1)
  task automatic get_byte(input logic nack, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      o_sda = 1'b1;
      #Q o_scl = 1'b1;
      #Q b[i] = i_sda;
      #Q o_scl = 1'b0;
      #Q;
    end
    o_sda = nack;
    #Q o_scl = 1'b1;
    #(2*Q) o_scl = 1'b0;
    #Q;
  endtask
endmodule
`default_nettype wire

// [testbench/test_eeprom_write_protect_control.sv]
// self-checking bench of the write-protect control through the two-wire bus
// assumes the bus master model and a short busy count
`timescale 1ns/1ps
`default_nettype none
module test_eeprom_write_protect_control;
  logic clk = 1'b0, lclk = 1'b0, rst_n = 1'b0, wp = 1'b0;
  logic scl, m_sda, oe, sda_o, commit, busy;
  logic [15:0] caddr, last;
  logic [7:0]  write_protect_control, rdata;
  int fails = 0, n_compared = 0, n_commit = 0;
  wire logic sda = (oe === 1'b1 || m_sda === 1'b0) ? 1'b0 : 1'b1;
  initial forever #10 clk = ~clk;
  initial begin
    #7;
    forever #32 lclk = ~lclk;
  end
  ewp_bus_master m (.o_scl(scl), .o_sda(m_sda), .i_sda(sda));
  ewp_ctrl #(.P_NV_CYCLES(30)) dut (
    .i_clk_sys(clk), .i_arst_n(rst_n), .i_clk_link(lclk), .i_scl(scl),
    .i_sda_i(sda), .o_sda_o(sda_o), .o_sda_oe(oe), .i_wp(wp),
    .i_dev_sel(3'h5), .o_arr_commit(commit), .o_arr_addr(caddr),
    .o_busy(busy), .o_wpr(write_protect_control));
  always @(posedge clk) if (commit === 1'b1) begin
    n_commit <= n_commit + 1;
    last     <= caddr;
  end
  // ----------------------------------------
  // compare and report
  // ----------------------------------------
  task automatic chk_bit(input logic got, input logic exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask
  // a busy count that never runs out ends the run
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 500) begin
      @(negedge clk);
      n++;
    end
    if (n == 500) begin
      fails++;
      end_of_test();
    end
  endtask
  // one byte write; rs puts a repeated start ahead of the closing stop
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic ack_exp,
                    input logic rs = 1'b0);
    logic k;
    m.start();
    m.put_byte(8'haa, k);
    m.put_byte(a[15:8], k);
    m.put_byte(a[7:0], k);
    m.put_byte(d, k);
    if (rs) m.start();
    m.stop();
    chk_bit(k, ack_exp, "data ack");
    settle(15);
  endtask
  // register read: dummy write to the register, repeated start, one byte, nack
  task automatic rd(output logic [7:0] d);
    logic k;
    m.start();
    m.put_byte(8'haa, k);
    m.put_byte(8'hff, k);
    m.put_byte(8'hff, k);
    m.start();
    m.put_byte(8'hab, k);
    m.get_byte(1'b1, d);
    m.stop();
    chk_bit(k, 1'b1, "read address ack");
    settle(15);
  endtask
  // keeps the run well under the cycle budget even if a transfer hangs
  initial begin
    #1900000;
    fails++;
    end_of_test();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    settle(4);
    rst_n = 1'b1;
    chk_byte(write_protect_control, 8'h00, "wpr");
    settle(10);
    wr(16'h0100, 8'h55, 1'b0);
    chk_word(16'(n_commit), 16'h0000, "commits");
    wr(16'hffff, 8'h02, 1'b1);
    chk_byte(write_protect_control, 8'h02, "wpr");
    chk_bit(busy, 1'b0, "busy");
    wr(16'hffff, 8'h06, 1'b1);
    chk_byte(write_protect_control, 8'h06, "wpr");
    wr(16'hffff, 8'h00, 1'b1);
    chk_byte(write_protect_control, 8'h06, "wpr");
    wr(16'hffff, 8'h0e, 1'b1);
    chk_byte(write_protect_control, 8'h06, "wpr");
    $display("test latches done");
    wr(16'hffff, 8'h9a, 1'b1);
    chk_bit(busy, 1'b1, "busy");
    wait_idle();
    chk_byte(write_protect_control, 8'h9a, "wpr");
    @(negedge clk) wp = 1'b1;
    wr(16'hffff, 8'h06, 1'b1);
    wr(16'hffff, 8'h0a, 1'b1);
    chk_bit(busy, 1'b0, "hw lock busy");
    chk_byte(write_protect_control, 8'h9e, "hw lock");
    @(negedge clk) wp = 1'b0;
    wr(16'hffff, 8'h0a, 1'b1, 1'b1);
    chk_bit(busy, 1'b0, "restart busy");
    chk_byte(write_protect_control, 8'h9e, "restart");
    wr(16'hffff, 8'h0a, 1'b1);
    wait_idle();
    chk_byte(write_protect_control, 8'h0a, "wpr");
    $display("test protect bits done");
    wr(16'hffff, 8'h06, 1'b1);
    chk_byte(write_protect_control, 8'h0e, "wpr");
    wr(16'h2fff, 8'h11, 1'b1);
    chk_word(last, 16'h2fff, "commit addr");
    wait_idle();
    chk_byte(write_protect_control, 8'h0a, "wpr");
    wr(16'h3000, 8'h11, 1'b1);
    chk_bit(busy, 1'b0, "locked busy");
    chk_word(16'(n_commit), 16'h0001, "commits");
    wr(16'hffff, 8'h00, 1'b1);
    chk_byte(write_protect_control, 8'h08, "wpr");
    rd(rdata);
    chk_byte(rdata, 8'h08, "read wpr");
    $display("test array lock done");
    end_of_test();
  end
endmodule
`default_nettype wire
